// >>> rtl/lidar_packet_body_tail_framer.sv
// module: body and crc tail framer for point cloud and inertial packets
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - cloud body opens with two-byte azimuth
// - sixteen three-byte channel entries, channel one first
// - entry starts with 16-bit distance count
// - entry ends with reflectivity byte
// - four contamination bytes, two bits per channel
// - state byte: normal or high temperature
// - selector byte then two-byte info value
// - software version pieces, little-endian ascii
// - firmware version pieces as ascii
// - cloud body ends with packet sequence number
// - inertial body: three signed accelerations X,Y,Z
// - then three signed angular rates X,Y,Z
// - inertial body ends with 16-bit sequence
// - four-byte crc over pre-header through body
// - inertial crc includes two untransmitted zero bytes
// - multi-byte fields sent low byte first
// - data type byte selects body format
module lidar_packet_body_tail_framer
  import framer_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // packet start: data type byte and captured body fields
  input wire logic i_start,
  input wire logic [7:0] i_data_type,
  input wire logic [31:0] i_crc_seed,
  input wire cloud_body_s i_cloud,
  input wire inertial_body_s i_inertial,
  // byte stream out
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_last,
  output logic o_busy,
  // register port
  input wire reg_req_s i_reg,
  output logic [31:0] o_rdata,
  output logic o_irq
);

  typedef enum {IDLE, BODY, PAD, TAIL} phase_e;

  phase_e phase;
  logic is_cloud;
  logic [CLOUD_BODY_BYTES*8-1:0] body_shift;
  logic [6:0] count;
  logic [31:0] crc;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_enable;
  logic [15:0] pkt_count;
  logic [31:0] last_crc;
  logic [7:0] cur_byte;
  logic done_evt;
  logic lost_evt;

  // one byte step of crc-32/mpeg-2: msb first, no reflection, no final xor
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[31] ^ d[i]) begin
        r = {r[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_step

  // swap a 16-bit field to wire order
  function automatic logic [15:0] le16(input logic [15:0] v);
    return {v[7:0], v[15:8]};
  endfunction : le16

  function automatic logic [31:0] le32(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction : le32

  // data type decode, used by the format flag and the body load
  function automatic logic is_cloud_type(input logic [7:0] t);
    return t == BODY_POINT_CLOUD;
  endfunction : is_cloud_type

  // index of the final body byte for the latched format
  function automatic logic [6:0] last_body_index(input logic cloud);
    return cloud ? 7'(CLOUD_BODY_BYTES-1) : 7'(INERTIAL_BODY_BYTES-1);
  endfunction : last_body_index

  // register write decode, shared by the clear and enable registers
  function automatic logic reg_write_hit(input reg_req_s req, input logic [3:0] a);
    return req.wr && (req.addr == a);
  endfunction : reg_write_hit

  // cloud body packed in transmit order, first byte at the top
  logic [CLOUD_BODY_BYTES*8-1:0] cloud_wire;
  logic [CLOUD_BODY_BYTES*8-1:0] inertial_wire;
  logic [BLOCK_BYTES*8-1:0] block_wire;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      // channel one first, each entry distance low byte, high byte, reflectivity
      assign block_wire[(BLOCK_BYTES-CHANNEL_BYTES*g)*8-1 -: 24] =
        {le16(i_cloud.channel[g].distance), i_cloud.channel[g].reflectivity};
    end
  endgenerate

  // the selector tells the host what the value means; the framer passes it intact,
  // so software and firmware version pieces go out exactly as supplied
  assign cloud_wire = {
    le16(i_cloud.azimuth),
    block_wire,
    le32(i_cloud.contamination),
    i_cloud.lidar_state,
    i_cloud.multiplexed_info_selector,
    le16(i_cloud.multiplexed_info_value),
    le16(i_cloud.packet_sequence_number)
  };

  assign inertial_wire = {
    le16(i_inertial.accel_x),
    le16(i_inertial.accel_y),
    le16(i_inertial.accel_z),
    le16(i_inertial.rate_x),
    le16(i_inertial.rate_y),
    le16(i_inertial.rate_z),
    le16(i_inertial.inertial_sequence_number),
    {(CLOUD_BODY_BYTES-INERTIAL_BODY_BYTES)*8{1'b0}}
  };

  assign cur_byte = body_shift[CLOUD_BODY_BYTES*8-1 -: 8];

  logic fire;
  logic accept;
  logic body_end;
  logic pad_end;
  logic tail_end;
  assign fire = o_valid && i_ready;
  assign accept = i_start && (phase == IDLE);
  assign body_end = (count == last_body_index(is_cloud));
  assign pad_end = (count == 7'(PAD_BYTES-1));
  assign tail_end = (count == 7'(CRC_BYTES-1));
  assign done_evt = (phase == TAIL) && fire && tail_end;
  // a start while busy is dropped and only flagged
  assign lost_evt = i_start && (phase != IDLE);

  // packet phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase <= IDLE;
    end else begin
      case (phase)
        IDLE: begin
          if (accept) begin
            phase <= BODY;
          end
        end
        BODY: begin
          if (fire && body_end) begin
            phase <= is_cloud ? TAIL : PAD;
          end
        end
        PAD: begin
          if (pad_end) begin
            phase <= TAIL;
          end
        end
        TAIL: begin
          if (fire && tail_end) begin
            phase <= IDLE;
          end
        end
        default: begin
          phase <= IDLE;
        end
      endcase
    end
  end

  // byte index within the current phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      count <= '0;
    end else begin
      case (phase)
        BODY: begin
          if (fire) begin
            count <= body_end ? 7'd0 : count + 7'd1;
          end
        end
        PAD: begin
          count <= pad_end ? 7'd0 : count + 7'd1;
        end
        TAIL: begin
          if (fire) begin
            count <= tail_end ? 7'd0 : count + 7'd1;
          end
        end
        default: begin
          count <= '0;
        end
      endcase
    end
  end

  // body format held for the whole packet
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      is_cloud <= 1'b0;
    end else if (accept) begin
      is_cloud <= is_cloud_type(i_data_type);
    end
  end

  // body bytes captured at the start, shifted out from the top
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      body_shift <= '0;
    end else if (accept) begin
      body_shift <= is_cloud_type(i_data_type) ? cloud_wire : inertial_wire;
    end else if ((phase == BODY) && fire) begin
      body_shift <= {body_shift[CLOUD_BODY_BYTES*8-9:0], 8'h00};
    end
  end

  // running crc, seeded with what the pre-header and header left in it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      crc <= CRC_INIT;
    end else begin
      case (phase)
        IDLE: begin
          if (accept) begin
            crc <= i_crc_seed;
          end
        end
        BODY: begin
          if (fire) begin
            crc <= crc_step(crc, cur_byte);
          end
        end
        PAD: begin
          // zero bytes enter the crc but never reach the stream
          crc <= crc_step(crc, 8'h00);
        end
        default: begin
          crc <= crc;
        end
      endcase
    end
  end

  // busy mirrors the phase, so a start is taken exactly while busy is low
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
    end else if (phase == IDLE) begin
      o_busy <= i_start;
    end else begin
      o_busy <= !done_evt;
    end
  end

  // output byte register; the crc goes out low byte first
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_valid <= 1'b0;
      o_byte <= 8'h00;
      o_last <= 1'b0;
    end else begin
      if (!o_valid || i_ready) begin
        o_valid <= 1'b0;
        o_last <= 1'b0;
        case (phase)
          BODY: begin
            if (!o_valid) begin
              o_valid <= 1'b1;
              o_byte <= cur_byte;
            end
          end
          TAIL: begin
            if (!o_valid) begin
              o_valid <= 1'b1;
              o_byte <= crc[8*count[1:0] +: 8];
              o_last <= (count == 7'(CRC_BYTES-1));
            end
          end
          default: o_valid <= 1'b0;
        endcase
      end
    end
  end

  // statistics
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pkt_count <= '0;
      last_crc <= '0;
    end else if (done_evt) begin
      pkt_count <= pkt_count + 16'd1;
      last_crc <= crc;
    end
  end

  // interrupts: an event in the same cycle as its clear stays set
  logic [IRQ_BITS-1:0] irq_clr;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] next_irq_status;
  logic [IRQ_BITS-1:0] next_irq_enable;

  always_comb begin
    irq_clr = '0;
    if (reg_write_hit(i_reg, REG_IRQ_CLEAR)) begin
      irq_clr = i_reg.wdata[IRQ_BITS-1:0];
    end
    irq_set = '0;
    irq_set[IRQ_DONE] = done_evt;
    irq_set[IRQ_START_LOST] = lost_evt;
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
    next_irq_enable = irq_enable;
    if (reg_write_hit(i_reg, REG_IRQ_ENABLE)) begin
      next_irq_enable = i_reg.wdata[IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_enable <= '0;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // the level follows the new status and enable, so it never lags a write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_irq_status & next_irq_enable);
    end
  end

  // read port: data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= '0;
      if (i_reg.rd) begin
        case (i_reg.addr)
          REG_STATUS: o_rdata <= {30'h0, is_cloud, phase != IDLE};
          REG_IRQ_STATUS: o_rdata <= {30'h0, irq_status};
          REG_IRQ_ENABLE: o_rdata <= {30'h0, irq_enable};
          REG_PKT_COUNT: o_rdata <= {16'h0, pkt_count};
          REG_LAST_CRC: o_rdata <= last_crc;
          default: o_rdata <= '0;
        endcase
      end
    end
  end

endmodule : lidar_packet_body_tail_framer

// >>> rtl/framer_pkg.sv
// package: constants and carriers for the packet body and tail framer
package framer_pkg;
  // data type byte values selecting the body format
  localparam logic [7:0] BODY_POINT_CLOUD = 8'h00;
  localparam logic [7:0] BODY_INERTIAL = 8'h01;
  // packet body, pad and crc tail layout in bytes
  localparam int AZIMUTH_BYTES = 2;
  localparam int CHANNELS = 16;
  localparam int CHANNEL_BYTES = 3;
  localparam int BLOCK_BYTES = 48;
  localparam int CONTAM_BYTES = 4;
  localparam int CLOUD_BODY_BYTES = 60;
  localparam int INERTIAL_BODY_BYTES = 14;
  localparam int CRC_BYTES = 4;
  localparam int PAD_BYTES = 2;
  // state byte codes
  localparam logic [7:0] STATE_NORMAL = 8'h00;
  localparam logic [7:0] STATE_HIGH_TEMP = 8'h01;
  // selector values
  localparam logic [7:0] SEL_MOTOR_SPEED = 8'h00;
  localparam logic [7:0] SEL_SW_FIRST = 8'h0f;
  localparam logic [7:0] SEL_SW_LAST = 8'h0c;
  localparam logic [7:0] SEL_FW_FIRST = 8'h13;
  localparam logic [7:0] SEL_FW_LAST = 8'h10;
  // crc-32/mpeg-2
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  // interrupt bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_START_LOST = 1;
  localparam int IRQ_BITS = 2;
  // register offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h2;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h3;
  localparam logic [3:0] REG_PKT_COUNT = 4'h4;
  localparam logic [3:0] REG_LAST_CRC = 4'h5;

  typedef struct packed {
    logic [15:0] distance;
    logic [7:0] reflectivity;
  } channel_s;

  typedef struct packed {
    logic [15:0] azimuth;
    channel_s [CHANNELS-1:0] channel;
    logic [31:0] contamination;
    logic [7:0] lidar_state;
    logic [7:0] multiplexed_info_selector;
    logic [15:0] multiplexed_info_value;
    logic [15:0] packet_sequence_number;
  } cloud_body_s;

  typedef struct packed {
    logic [15:0] accel_x;
    logic [15:0] accel_y;
    logic [15:0] accel_z;
    logic [15:0] rate_x;
    logic [15:0] rate_y;
    logic [15:0] rate_z;
    logic [15:0] inertial_sequence_number;
  } inertial_body_s;

  typedef struct packed {
    logic [31:0] wdata;
    logic [3:0] addr;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage : framer_pkg

// >>> testbench/framer_checker.sv
// checker: stream timing and field order at the framer ports
`timescale 1ns/1ps
module framer_checker
  import framer_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [7:0] i_data_type,
  input wire cloud_body_s i_cloud,
  input wire inertial_body_s i_inertial,
  input wire logic i_ready,
  input wire logic o_valid,
  input wire logic [7:0] o_byte,
  input wire logic o_last,
  input wire logic o_busy,
  input wire reg_req_s i_reg,
  input wire logic [31:0] o_rdata
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic go;
  logic cl;
  logic [6:0] n;
  logic [15:0] f;
  assign go = i_start && !o_busy;
  // a refused start must not restart the byte count
  always_ff @(posedge i_clk) begin
    if (go) begin
      n <= 7'h0;
      cl <= (i_data_type == BODY_POINT_CLOUD);
      f <= (i_data_type == BODY_POINT_CLOUD) ? i_cloud.azimuth : i_inertial.accel_x;
    end else if (o_valid && i_ready) begin
      n <= n + 7'h1;
    end
  end
  property p_answer; go |-> ##2 o_valid; endproperty
  a_answer: assert property (p_answer) else $error("no byte two cycles after start");
  property p_busy; go |=> o_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy not raised by start");
  property p_hold; o_valid && !i_ready |=> o_valid && $stable(o_byte) && $stable(o_last); endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");
  property p_gap; o_valid && i_ready |=> !o_valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle after a take");
  property p_vb; o_valid |-> o_busy; endproperty
  a_vb: assert property (p_vb) else $error("valid outside a packet");
  property p_len; o_valid && i_ready && o_last |-> n == (cl ? 7'h3f : 7'h11); endproperty
  a_len: assert property (p_len) else $error("wrong packet length");
  property p_first; o_valid && n == 7'h0 |-> o_byte == f[7:0]; endproperty
  a_first: assert property (p_first) else $error("first byte wrong");
  property p_second; o_valid && n == 7'h1 |-> o_byte == f[15:8]; endproperty
  a_second: assert property (p_second) else $error("second byte wrong");
  property p_rdata; !i_reg.rd |=> o_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside a read");
  c_cloud: cover property (go && i_data_type == BODY_POINT_CLOUD);
  c_inert: cover property (go && i_data_type == BODY_INERTIAL);
  c_stall: cover property (o_valid && !i_ready);
endmodule : framer_checker

bind lidar_packet_body_tail_framer framer_checker chk_u (.i_clk, .i_sys_rst, .i_start,
  .i_data_type, .i_cloud, .i_inertial, .i_ready, .o_valid, .o_byte, .o_last, .o_busy,
  .i_reg, .o_rdata);

// >>> testbench/host_sink.sv
// host side model: takes the framed byte stream, may stall
`timescale 1ns/1ps
module host_sink #(
  // azimuth offset of the channel whose angle the host tracks, hundredths of a degree
  parameter logic [15:0] CH_OFFSET = 16'h0145
) (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic o_ready
);
  logic [7:0] got[$];
  logic [1:0] ph = 2'h0;
  logic [15:0] horiz_angle;
  // slow mode accepts one cycle in four to stretch every byte
  always @(posedge i_clk) begin
    ph <= ph + 2'h1;
    o_ready <= !i_slow || ph == 2'h3;
    if (i_valid && o_ready) begin
      // the second byte completes the block azimuth
      if (got.size() == 1) horiz_angle <= {i_byte, got[0]} + CH_OFFSET;
      got.push_back(i_byte);
    end
  end
endmodule : host_sink

// >>> testbench/testbench.sv
// testbench: packet bodies, crc tail and registers of the framer
`timescale 1ns/1ps
module testbench
  import framer_pkg::*;
;
  logic clk, rst, start, ready, valid, last, busy, irq, slow;
  logic [7:0] dtype, byte_q;
  logic [31:0] seed, rdata, last_crc;
  cloud_body_s cloud;
  inertial_body_s inert;
  reg_req_s reg_s;
  logic [7:0] exp[$];
  int num_errors = 0;
  int cmp_count = 0;
  lidar_packet_body_tail_framer dut_u (.i_clk(clk), .i_sys_rst(rst), .i_start(start),
    .i_data_type(dtype), .i_crc_seed(seed), .i_cloud(cloud), .i_inertial(inert),
    .i_ready(ready), .o_valid(valid), .o_byte(byte_q), .o_last(last), .o_busy(busy),
    .i_reg(reg_s), .o_rdata(rdata), .o_irq(irq));
  host_sink host_u (.i_clk(clk), .i_slow(slow), .i_valid(valid), .i_byte(byte_q),
    .o_ready(ready));
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    cmp_count++;
    if (g !== w) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, w);
    end
  endtask : chk
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = (c << 1) ^ ((c[31] ^ b[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction : crc8
  task automatic put16(input logic [15:0] v);
    exp.push_back(v[7:0]);
    exp.push_back(v[15:8]);
  endtask : put16
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) reg_s <= '{d, a, 1'b1, 1'b0};
    @(posedge clk) reg_s <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk) reg_s <= '{32'h0, a, 1'b0, 1'b1};
    @(posedge clk) reg_s <= '0;
    #1 chk(rdata, w);
  endtask : rd
  task automatic pkt(input logic [7:0] t, input logic lose);
    logic [31:0] c;
    @(posedge clk) begin
      start <= 1'b1;
      dtype <= t;
    end
    exp = {};
    host_u.got = {};
    if (t == BODY_POINT_CLOUD) begin
      put16(cloud.azimuth);
      for (int k = 0; k < CHANNELS; k++) begin
        put16(cloud.channel[k].distance);
        exp.push_back(cloud.channel[k].reflectivity);
      end
      put16(cloud.contamination[15:0]);
      put16(cloud.contamination[31:16]);
      exp.push_back(cloud.lidar_state);
      exp.push_back(cloud.multiplexed_info_selector);
      put16(cloud.multiplexed_info_value);
      put16(cloud.packet_sequence_number);
    end else begin
      for (int k = 6; k >= 0; k--) put16(inert[k*16 +: 16]);
    end
    c = seed;
    foreach (exp[i]) c = crc8(c, exp[i]);
    if (t != BODY_POINT_CLOUD) c = crc8(crc8(c, 8'h00), 8'h00);
    for (int i = 0; i < 4; i++) exp.push_back(c[8*i +: 8]);
    last_crc = c;
    @(posedge clk) start <= 1'b0;
    if (lose) begin
      // a start while busy is dropped and only flagged
      repeat (3) @(posedge clk);
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
    end
    for (int i = 0; i < 4000 && (busy || host_u.got.size() < exp.size()); i++) @(posedge clk);
    chk(busy, 1'b0);
    chk(host_u.got.size(), exp.size());
    if (t == BODY_POINT_CLOUD) begin
      chk(host_u.horiz_angle, 16'(cloud.azimuth + host_u.CH_OFFSET));
    end
    foreach (exp[i]) chk(host_u.got[i], exp[i]);
  endtask : pkt
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
  initial begin
    {rst, start, slow, dtype, reg_s} = {1'b1, 1'b0, 1'b0, 8'h00, 38'h0};
    seed = 32'h1234abcd;
    for (int i = 0; i < $bits(cloud); i += 8) cloud[i +: 8] = 8'(i * 7 + 3);
    for (int i = 0; i < $bits(inert); i += 8) inert[i +: 8] = 8'(i * 5 + 129);
    cloud.lidar_state = STATE_NORMAL;
    cloud.multiplexed_info_selector = SEL_MOTOR_SPEED;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(REG_IRQ_ENABLE, 32'h3);
    pkt(BODY_POINT_CLOUD, 1'b0);
    rd(REG_IRQ_STATUS, 32'h1);
    chk(irq, 1'b1);
    wr(REG_IRQ_CLEAR, 32'h1);
    rd(REG_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    slow <= 1'b1;
    pkt(BODY_INERTIAL, 1'b1);
    rd(REG_IRQ_STATUS, 32'h3);
    rd(REG_LAST_CRC, last_crc);
    wr(REG_IRQ_ENABLE, 32'h0);
    rd(REG_IRQ_ENABLE, 32'h0);
    chk(irq, 1'b0);
    slow <= 1'b0;
    cloud.lidar_state <= STATE_HIGH_TEMP;
    cloud.multiplexed_info_selector <= SEL_FW_FIRST;
    pkt(BODY_POINT_CLOUD, 1'b0);
    rd(REG_PKT_COUNT, 32'h3);
    rd(4'hf, 32'h0);
    print_verdict;
  end
endmodule : testbench
